// [common/prc_pkg.sv]
/*
 Holds the constants and state types shared by the pulse rate and up/down counter block.
 Assumes a single 200 MHz system clock and an active-low asynchronous reset.
*/
package prc_pkg;

    // System clock rate in kHz, giving cycles per millisecond.
    localparam int CLK_KHZ = 200000;
    localparam int MS_CYCLES = CLK_KHZ;

    // Default input filter time in milliseconds and its cycle count.
    localparam int FILTER_MS = 50;
    localparam int FILTER_CYCLES = FILTER_MS * MS_CYCLES;

    // Shortest gate interval in milliseconds.
    localparam logic [31:0] GATE_MIN_MS = 32'h0000_000A;

    // Widths of thresholds, gate time, preset and exported values.
    localparam int ON_W = 27;
    localparam int OFF_W = 30;
    localparam int GATE_W = 32;
    localparam int PRESET_W = 27;
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;

    // Zero and one constants and the word export limit.
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] ONE32 = 32'h0000_0001;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;

    // Input filter state.
    typedef struct packed {
        logic level;
        logic level_d;
        logic [31:0] cnt;
    } prc_filt_s;

    // Main block state.
    typedef struct packed {
        logic en_d;
        logic run;
        logic [31:0] tick_cnt;
        logic [31:0] ms_cnt;
        logic [31:0] edge_cnt;
        logic [31:0] rate;
        logic fq;
        logic [31:0] ud_val;
        logic ud_q;
    } prc_state_s;

endpackage

// [core/prc_in_filt.sv]
/*
 Holds one input conditioner: a stability filter with a bypass for high-speed running,
 followed by rising and falling edge detection.
 Assumes the raw input is synchronous to clk.
*/
`timescale 1ns/1ps
module prc_in_filt import prc_pkg::*; #(
    parameter int FILT_CYCLES = FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic raw,
    input wire logic bypass,
    output logic rise,
    output logic fall
);

    prc_filt_s st_ff;
    prc_filt_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.level_d = st_ff.level;
        if (bypass || raw == st_ff.level) begin
            nxt_st.cnt = ZERO32;
            nxt_st.level = bypass ? raw : st_ff.level;
        end else if (st_ff.cnt >= 32'(FILT_CYCLES - 1)) begin
            nxt_st.cnt = ZERO32;
            nxt_st.level = raw;
        end else begin
            nxt_st.cnt = st_ff.cnt + ONE32;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise = st_ff.level && !st_ff.level_d;
    assign fall = !st_ff.level && st_ff.level_d;

endmodule

// [core/prc_top.sv]
/*
 Holds the pulse rate threshold switch and the up/down pulse counter.
 Assumes all inputs are synchronous to clk and thresholds stay steady during a gate.
*/
`timescale 1ns/1ps
module prc_top import prc_pkg::*; #(
    parameter int MS_CYC = MS_CYCLES,
    parameter int FILT_CYC = FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic freq_enable,
    input wire logic count_in,
    input wire logic freq_reset,
    input wire logic falling_mode,
    input wire logic freq_high_speed,
    input wire logic [ON_W-1:0] on_threshold,
    input wire logic [OFF_W-1:0] off_threshold,
    input wire logic [GATE_W-1:0] gate_ms,
    input wire logic up_pulse,
    input wire logic down_pulse,
    input wire logic ud_reset,
    input wire logic [PRESET_W-1:0] ud_preset,
    input wire logic ud_retain,
    input wire logic ud_high_speed,
    input wire logic restart,
    output logic freq_gate_switch,
    output logic [31:0] measured_rate,
    output logic [WORD_W-1:0] freq_value,
    output logic ud_switch,
    output logic [DWORD_W-1:0] ud_value
);

    prc_state_s st_ff;
    prc_state_s nxt_st;
    logic cnt_rise;
    logic cnt_fall;
    logic up_rise;
    logic down_rise;
    logic qual_edge;
    logic ms_tick;
    logic gate_end;
    logic [31:0] gate_len;
    logic [31:0] on_ext;
    logic [31:0] off_ext;
    logic [31:0] preset_ext;

    prc_in_filt #(.FILT_CYCLES(FILT_CYC)) u_cnt_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw(count_in),
        .bypass(freq_high_speed),
        .rise(cnt_rise),
        .fall(cnt_fall)
    );

    prc_in_filt #(.FILT_CYCLES(FILT_CYC)) u_up_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw(up_pulse),
        .bypass(ud_high_speed),
        .rise(up_rise),
        .fall()
    );

    prc_in_filt #(.FILT_CYCLES(FILT_CYC)) u_down_filt (
        .clk(clk),
        .reset_n(reset_n),
        .raw(down_pulse),
        .bypass(ud_high_speed),
        .rise(down_rise),
        .fall()
    );

    assign on_ext = 32'(on_threshold);
    assign off_ext = 32'(off_threshold);
    assign preset_ext = 32'(ud_preset);

    assign qual_edge = falling_mode ? cnt_fall : cnt_rise;

    assign gate_len = (gate_ms < GATE_MIN_MS) ? GATE_MIN_MS : gate_ms;
    assign ms_tick = st_ff.run && (st_ff.tick_cnt == 32'(MS_CYC - 1));
    assign gate_end = ms_tick && (st_ff.ms_cnt + ONE32 >= gate_len);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.en_d = freq_enable;
        // Gate timebase runs only while measuring.
        if (st_ff.run) begin
            nxt_st.tick_cnt = ms_tick ? ZERO32 : st_ff.tick_cnt + ONE32;
            if (ms_tick) begin
                nxt_st.ms_cnt = gate_end ? ZERO32 : st_ff.ms_cnt + ONE32;
            end
            if (gate_end) begin
                nxt_st.rate = st_ff.edge_cnt;
                nxt_st.edge_cnt = qual_edge ? ONE32 : ZERO32;
            end else if (qual_edge) begin
                nxt_st.edge_cnt = st_ff.edge_cnt + ONE32;
            end
        end
        if (freq_enable && !st_ff.en_d) begin
            nxt_st.run = 1'b1;
            nxt_st.tick_cnt = ZERO32;
            nxt_st.ms_cnt = ZERO32;
            nxt_st.edge_cnt = ZERO32;
        end else if (!freq_enable && st_ff.en_d) begin
            nxt_st.run = 1'b0;
        end
        // Threshold decision on each freshly latched rate.
        if (gate_end) begin
            if (on_ext >= off_ext) begin
                if (st_ff.edge_cnt >= on_ext) begin
                    nxt_st.fq = 1'b1;
                end else if (st_ff.edge_cnt < off_ext) begin
                    nxt_st.fq = 1'b0;
                end
            end else begin
                nxt_st.fq = (st_ff.edge_cnt >= on_ext) && (st_ff.edge_cnt < off_ext);
            end
        end
        if (freq_reset) begin
            nxt_st.edge_cnt = ZERO32;
            nxt_st.rate = ZERO32;
            nxt_st.fq = 1'b0;
            nxt_st.tick_cnt = ZERO32;
            nxt_st.ms_cnt = ZERO32;
        end

        if (up_rise && !down_rise) begin
            nxt_st.ud_val = st_ff.ud_val + ONE32;
        end else if (down_rise && !up_rise) begin
            nxt_st.ud_val = st_ff.ud_val - ONE32;
        end
        if (restart && !ud_retain) begin
            nxt_st.ud_val = ZERO32;
        end
        if (ud_reset) begin
            nxt_st.ud_val = ZERO32;
        end
        nxt_st.ud_q = !ud_reset && ($signed(nxt_st.ud_val) >= $signed(preset_ext));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign freq_gate_switch = st_ff.fq;
    assign measured_rate = st_ff.rate;
    assign freq_value = (st_ff.rate > 32'(WORD_MAX)) ? WORD_MAX : st_ff.rate[WORD_W-1:0];
    assign ud_switch = st_ff.ud_q;
    assign ud_value = st_ff.ud_val;

    chk_en_starts: assert property (@(posedge clk) disable iff (!reset_n)
        freq_enable && !st_ff.en_d && !freq_reset |=> st_ff.run && st_ff.ms_cnt == ZERO32 && st_ff.edge_cnt == ZERO32)
        else $error("Enable edge did not start a measurement.");

    chk_rise_counts: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.run && !falling_mode && cnt_rise && !gate_end && !freq_reset && !(freq_enable && !st_ff.en_d)
        |=> st_ff.edge_cnt == $past(st_ff.edge_cnt) + ONE32)
        else $error("Rising edge was not counted.");

    chk_rise_ignored: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.run && falling_mode && !cnt_fall && !gate_end && !freq_reset && !(freq_enable && !st_ff.en_d)
        |=> st_ff.edge_cnt == $past(st_ff.edge_cnt))
        else $error("Count moved without a falling edge in falling mode.");

    chk_freq_reset: assert property (@(posedge clk) disable iff (!reset_n)
        freq_reset |=> !freq_gate_switch && st_ff.edge_cnt == ZERO32 && measured_rate == ZERO32)
        else $error("Rate reset did not clear count and switch.");

    chk_hyst_set: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end && !freq_reset && on_ext >= off_ext && st_ff.edge_cnt >= on_ext |=> freq_gate_switch)
        else $error("Switch not set at on threshold.");

    chk_window_out: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end && !freq_reset && on_ext < off_ext
        |=> freq_gate_switch == ($past(st_ff.edge_cnt) >= $past(on_ext) && $past(st_ff.edge_cnt) < $past(off_ext)))
        else $error("Window switch output wrong.");

    chk_rate_latch: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end && !freq_reset |=> measured_rate == $past(st_ff.edge_cnt))
        else $error("Rate not latched at gate end.");

    chk_ud_reset: assert property (@(posedge clk) disable iff (!reset_n)
        ud_reset |=> ud_value == ZERO32 && !ud_switch)
        else $error("Counter reset did not win.");

    chk_ud_up: assert property (@(posedge clk) disable iff (!reset_n)
        up_rise && !down_rise && !ud_reset && !restart |=> ud_value == $past(ud_value) + ONE32)
        else $error("Up edge did not increment.");

    chk_ud_preset: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && !$past(ud_reset)
        |-> ud_switch == ($signed(ud_value) >= $signed(32'(ud_preset))) || $changed(ud_preset))
        else $error("Preset output disagrees with value.");

    chk_en_stops: assert property (@(posedge clk) disable iff (!reset_n)
        !freq_enable && st_ff.en_d |=> !st_ff.run)
        else $error("Enable fall did not stop the gate.");

    chk_idle_frozen: assert property (@(posedge clk) disable iff (!reset_n)
        !st_ff.run && !(freq_enable && !st_ff.en_d) && !freq_reset
        |=> $stable(st_ff.edge_cnt) && $stable(measured_rate))
        else $error("Count moved while no measurement ran.");

    chk_fall_counts: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.run && falling_mode && cnt_fall && !gate_end && !freq_reset
        |=> st_ff.edge_cnt == $past(st_ff.edge_cnt) + ONE32)
        else $error("Falling edge was not counted.");

    chk_fall_ignored: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.run && !falling_mode && !cnt_rise && !gate_end && !freq_reset
        |=> st_ff.edge_cnt == $past(st_ff.edge_cnt))
        else $error("Count moved without a rising edge in rising mode.");

    chk_gate_restart: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end && !freq_reset |=> st_ff.edge_cnt == ($past(qual_edge) ? ONE32 : ZERO32))
        else $error("Edge count did not restart at gate end.");

    chk_hyst_clear: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end && !freq_reset && on_ext >= off_ext && st_ff.edge_cnt < off_ext
        |=> !freq_gate_switch)
        else $error("Switch not cleared below off threshold.");

    chk_hyst_hold: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end && !freq_reset && on_ext >= off_ext && st_ff.edge_cnt < on_ext && st_ff.edge_cnt >= off_ext
        |=> $stable(freq_gate_switch))
        else $error("Switch moved inside the hysteresis band.");

    chk_switch_steady: assert property (@(posedge clk) disable iff (!reset_n)
        !gate_end && !freq_reset |=> $stable(freq_gate_switch) && $stable(measured_rate))
        else $error("Rate or switch moved between gate ends.");

    chk_gate_floor: assert property (@(posedge clk) disable iff (!reset_n)
        gate_end |-> st_ff.ms_cnt + ONE32 >= GATE_MIN_MS)
        else $error("Gate closed before the shortest interval.");

    chk_ms_timebase: assert property (@(posedge clk) disable iff (!reset_n)
        st_ff.run && !ms_tick && !freq_reset
        |=> st_ff.tick_cnt == $past(st_ff.tick_cnt) + ONE32)
        else $error("Millisecond timebase skipped a cycle.");

    chk_gate_timers: assert property (@(posedge clk) disable iff (!reset_n)
        freq_reset |=> st_ff.tick_cnt == ZERO32 && st_ff.ms_cnt == ZERO32)
        else $error("Rate reset did not clear the gate timers.");

    chk_word_export: assert property (@(posedge clk) disable iff (!reset_n)
        measured_rate <= 32'(WORD_MAX) |-> 32'(freq_value) == measured_rate)
        else $error("Word export differs from the measured rate.");

    chk_ud_down: assert property (@(posedge clk) disable iff (!reset_n)
        down_rise && !up_rise && !ud_reset && !restart |=> ud_value == $past(ud_value) - ONE32)
        else $error("Down edge did not decrement.");

    chk_ud_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !up_rise && !down_rise && !ud_reset && !restart |=> $stable(ud_value))
        else $error("Counter moved without a rising count edge.");

    chk_ud_retain: assert property (@(posedge clk) disable iff (!reset_n)
        restart && ud_retain && !ud_reset && !up_rise && !down_rise |=> $stable(ud_value))
        else $error("Retained count was lost on restart.");

    chk_ud_restart: assert property (@(posedge clk) disable iff (!reset_n)
        restart && !ud_retain |=> ud_value == ZERO32)
        else $error("Restart did not clear the counter.");

    cov_gate_end: cover property (@(posedge clk) disable iff (!reset_n) gate_end);
    cov_window_on: cover property (@(posedge clk) disable iff (!reset_n)
        gate_end && on_ext < off_ext && st_ff.edge_cnt >= on_ext && st_ff.edge_cnt < off_ext);
    cov_ud_below_zero: cover property (@(posedge clk) disable iff (!reset_n) down_rise && ud_value == ZERO32);
    cov_switch_on: cover property (@(posedge clk) disable iff (!reset_n) $rose(freq_gate_switch));
    cov_ud_hit: cover property (@(posedge clk) disable iff (!reset_n) $rose(ud_switch));

endmodule

// [sim/prc_pulse_src.sv]
/*
 Pulse source model for the rate input and the up and down count inputs.
 Assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module prc_pulse_src (
    input wire logic clk,
    output logic count_in,
    output logic up_pulse,
    output logic down_pulse
);
    initial begin
        count_in = 1'b0;
        up_pulse = 1'b0;
        down_pulse = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_line(input int which, input logic v);
        case (which)
            0: count_in = v;
            1: up_pulse = v;
            default: down_pulse = v;
        endcase
    endtask
    task automatic burst(input int which, input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            set_line(which, 1'b1);
            wt(hi);
            set_line(which, 1'b0);
            wt(lo);
        end
    endtask
endmodule

// [sim/tb_prc_top.sv]
/*
 Self-checking testbench for the pulse rate switch and the up/down counter.
 Assumes shortened timing: 4 cycles per millisecond and an 8-cycle input filter.
*/
`timescale 1ns/1ps
module tb_prc_top;
    import prc_pkg::*;
    logic clk, reset_n, freq_enable, freq_reset, falling_mode, freq_high_speed;
    logic [ON_W-1:0] on_threshold;
    logic [OFF_W-1:0] off_threshold;
    logic [GATE_W-1:0] gate_ms;
    logic ud_reset, ud_retain, ud_high_speed, restart;
    logic [PRESET_W-1:0] ud_preset;
    logic count_in, up_pulse, down_pulse, freq_gate_switch, ud_switch;
    logic [31:0] measured_rate;
    logic [WORD_W-1:0] freq_value;
    logic [DWORD_W-1:0] ud_value;
    int failures = 0;
    int n_compared = 0;

    prc_pulse_src src (.clk(clk), .count_in(count_in), .up_pulse(up_pulse), .down_pulse(down_pulse));
    prc_top #(.MS_CYC(4), .FILT_CYC(8)) dut (.clk(clk), .reset_n(reset_n), .freq_enable(freq_enable),
        .count_in(count_in), .freq_reset(freq_reset), .falling_mode(falling_mode),
        .freq_high_speed(freq_high_speed), .on_threshold(on_threshold), .off_threshold(off_threshold),
        .gate_ms(gate_ms), .up_pulse(up_pulse), .down_pulse(down_pulse), .ud_reset(ud_reset),
        .ud_preset(ud_preset), .ud_retain(ud_retain), .ud_high_speed(ud_high_speed), .restart(restart),
        .freq_gate_switch(freq_gate_switch), .measured_rate(measured_rate), .freq_value(freq_value),
        .ud_switch(ud_switch), .ud_value(ud_value));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic ud_chk(input logic [31:0] v, input logic s);
        chk_val("ud_value", v, ud_value);
        chk_bit("ud_switch", s, ud_switch);
    endtask
    // One gate: a lone falling edge, then n full pulses, all inside the first gate.
    task automatic measure(input logic fm, input int on, input int off, input int n,
                           input logic [31:0] er, input logic es);
        falling_mode = fm;
        on_threshold = on[ON_W-1:0];
        off_threshold = off[OFF_W-1:0];
        src.set_line(0, 1'b1);
        step(4);
        freq_enable = 1'b1;
        step(2);
        src.set_line(0, 1'b0);
        step(2);
        src.burst(0, n, 2, 2);
        step(44 - 4 * n);
        chk_val("measured_rate", er, measured_rate);
        chk_val("freq_value", {16'h0000, er[15:0]}, {16'h0000, freq_value});
        chk_bit("freq_gate_switch", es, freq_gate_switch);
        freq_enable = 1'b0;
        step(2);
    endtask

    initial begin
        reset_n = 1'b0;
        freq_enable = 1'b0;
        freq_reset = 1'b0;
        falling_mode = 1'b0;
        freq_high_speed = 1'b1;
        on_threshold = '0;
        off_threshold = '0;
        gate_ms = 32'h0000000A;
        ud_reset = 1'b0;
        ud_retain = 1'b0;
        ud_high_speed = 1'b1;
        restart = 1'b0;
        ud_preset = 27'h0000003;
        step(3);
        ud_chk(32'h00000000, 1'b0);
        chk_val("measured_rate", 32'h00000000, measured_rate);
        reset_n = 1'b1;
        step(2);
        src.burst(1, 2, 2, 2);
        ud_chk(32'h00000002, 1'b0);
        src.burst(1, 1, 2, 2);
        ud_chk(32'h00000003, 1'b1);
        src.burst(2, 4, 2, 2);
        ud_chk(32'hFFFFFFFF, 1'b0);
        ud_retain = 1'b1;
        restart = 1'b1;
        step(1);
        restart = 1'b0;
        step(2);
        ud_chk(32'hFFFFFFFF, 1'b0);
        ud_retain = 1'b0;
        restart = 1'b1;
        step(1);
        restart = 1'b0;
        step(2);
        ud_chk(32'h00000000, 1'b0);
        src.burst(1, 3, 2, 2);
        ud_reset = 1'b1;
        src.burst(1, 3, 2, 2);
        ud_chk(32'h00000000, 1'b0);
        ud_reset = 1'b0;
        ud_high_speed = 1'b0;
        src.burst(1, 1, 3, 3);
        step(10);
        ud_chk(32'h00000000, 1'b0);
        src.burst(1, 1, 12, 12);
        ud_chk(32'h00000001, 1'b0);
        measure(1'b0, 5, 3, 6, 32'h00000006, 1'b1);
        measure(1'b0, 5, 3, 4, 32'h00000004, 1'b1);
        measure(1'b0, 5, 3, 2, 32'h00000002, 1'b0);
        measure(1'b1, 5, 3, 4, 32'h00000005, 1'b1);
        measure(1'b0, 3, 5, 5, 32'h00000005, 1'b0);
        measure(1'b0, 3, 5, 3, 32'h00000003, 1'b1);
        freq_reset = 1'b1;
        freq_enable = 1'b1;
        src.burst(0, 3, 2, 2);
        step(40);
        chk_val("measured_rate", 32'h00000000, measured_rate);
        chk_bit("freq_gate_switch", 1'b0, freq_gate_switch);
        freq_reset = 1'b0;
        freq_enable = 1'b0;
        step(2);
        measure(1'b0, 99999999, 999999999, 2, 32'h00000002, 1'b0);
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict();
    end
endmodule
